// ---- hdl/ashi_top.sv ----
// serial host interface of a multichannel converter: spi slave, config
// registers, 5-bit conversion commands, convert start and multi-function pin
// assumes sck well below clock/4; core signals share this clock
// Functional notes
// R1: a low hardware reset returns every configuration register to its default.
// R2: in register mode a read transaction shifts register contents out on sdo.
// R3: in conversion mode the conversion result is shifted out on sdo.
// R4: sdo changes only on a falling edge of the serial clock (or frame start); the code also loads sdo when a result lands under a held-low chip select.
// R5: the host serial clock times both sdo output and sdi input in both modes.
// R6: in register mode sdi carries read and write transactions that are decoded.
// R7: in conversion mode each 5-bit sdi command is accepted and acted on; the code acts only on a frame's first command, if channel select or exit.
// R8: in conversion mode a convert_start rising edge starts one conversion.
// R9: in register mode chip select low frames each register transaction.
// R10: in conversion mode the host may hold chip select low or frame each readback.
// R11: a 4-wire host may tie convert_start to chip select.
// R12: the multi-function pin serves as gpio, alert, busy or second sdo.
// R13: sdi is sampled on the rising serial clock edge.
`timescale 1ns/1ns
`include "ashi_defs.svh"
module ashi_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic convert_start,
  input wire logic multi_function_pin_in,
  output logic sdo,
  output logic multi_function_pin_out,
  output logic multi_function_pin_oe,
  output logic conv_start,
  input wire logic conv_done,
  input wire ashi_pkg::ashi_result_t conv_data,
  input wire logic alert_flag,
  output ashi_pkg::ashi_chan_t channel_sel,
  output logic conversion_mode
);
  import ashi_pkg::*;

  function automatic logic reg_mapped(input logic [6:0] a);
    return a < 7'(`ASHI_REG_COUNT);
  endfunction

  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] v,
                                          input logic [7:0] st);
    if (!reg_mapped(a))
      return 8'h00;
    else if (a[3:0] == `ASHI_REG_STATUS)
      return st;
    else
      return v;
  endfunction

  logic [4:0] pin_s;
  logic sck_s, cs_s, sdi_s, cnv_s, mfp_s;
  logic sck_rise, sck_fall, cs_fall, cnv_rise;

  // pins cross into the clock domain before anything looks at them
  ashi_sync #(.WIDTH(5)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pins({multi_function_pin_in, convert_start, sdi, ~cs_n, sck}), // cleared flop: deselected
    .pins_sync(pin_s)
  );
  assign sck_s = pin_s[0];
  assign cs_s = ~pin_s[1];
  assign sdi_s = pin_s[2];
  assign cnv_s = pin_s[3];
  assign mfp_s = pin_s[4];

  logic [7:0] reg_q [`ASHI_REG_COUNT];
  logic [7:0] reg_d [`ASHI_REG_COUNT];
  ashi_phase_t phase_q, phase_d;
  ashi_conv_t conv_st_q, conv_st_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] rx_q, rx_d;
  logic [15:0] tx_q, tx_d;
  logic [7:0] tx2_q, tx2_d;
  logic [6:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic sdo_q, sdo_d, sdo2_q, sdo2_d;
  ashi_result_t result_q, result_d;
  ashi_chan_t chan_q, chan_d;
  logic conv_start_q, conv_start_d;
  logic mfp_out_q, mfp_out_d, mfp_oe_q, mfp_oe_d;
  logic sck_p_q, cs_p_q, cnv_p_q;

  logic conv_mode;
  ashi_mfp_t mfp_sel;
  logic dual;
  logic [7:0] status;
  logic [15:0] rx_next;
  logic ld_done;
  ashi_result_t ld_src;

  assign sck_rise = sck_s & ~sck_p_q;
  assign sck_fall = ~sck_s & sck_p_q;
  assign cs_fall = ~cs_s & cs_p_q;
  assign cnv_rise = cnv_s & ~cnv_p_q;
  assign conv_mode = reg_q[`ASHI_REG_MODE][`ASHI_MODE_CONV_BIT];
  assign mfp_sel = ashi_mfp_t'(reg_q[`ASHI_REG_MFP][`ASHI_MFP_SEL_MSB:`ASHI_MFP_SEL_LSB]);
  assign dual = conv_mode && (mfp_sel == MFP_SDO2);
  assign rx_next = {rx_q[14:0], sdi_s};
  // held-low chip select: a fresh result is presented once, before any clocking
  assign ld_done = (conv_st_q == CV_BUSY) && conv_done && conv_mode && !cs_s &&
                   !cs_fall && (bit_cnt_q == 5'h00) && !sck_fall;
  assign ld_src = cs_fall ? result_q : conv_data;

  always_comb begin
    status = 8'h00;
    status[`ASHI_STAT_GPIN_BIT] = mfp_s;
    status[`ASHI_STAT_BUSY_BIT] = (conv_st_q == CV_BUSY);
    status[`ASHI_STAT_ALERT_BIT] = alert_flag;
  end

  always_comb begin
    reg_d = reg_q;
    phase_d = phase_q;
    conv_st_d = conv_st_q;
    bit_cnt_d = bit_cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    tx2_d = tx2_q;
    addr_d = addr_q;
    rd_d = rd_q;
    sdo_d = sdo_q;
    sdo2_d = sdo2_q;
    result_d = result_q;
    chan_d = chan_q;
    conv_start_d = 1'b0;
    // conversion request; edges during a busy conversion are ignored
    if (conv_mode && cnv_rise && (conv_st_q == CV_IDLE)) begin // [R8] [R11]
      conv_start_d = 1'b1;
      conv_st_d = CV_BUSY;
    end
    if ((conv_st_q == CV_BUSY) && conv_done) begin
      result_d = conv_data;
      conv_st_d = CV_IDLE;
    end
    if (cs_s) begin // [R9]
      phase_d = PH_IDLE;
      bit_cnt_d = 5'h00;
    end else if (cs_fall || ld_done) begin // [R3] [R10]
      if (cs_fall) begin
        phase_d = conv_mode ? PH_CMD : PH_ADDR;
        bit_cnt_d = 5'h00;
        rx_d = 16'h0000;
      end
      if (conv_mode && dual) begin // [R12]
        sdo_d = ld_src[15];
        tx_d = {ld_src[14:8], 9'h000};
        sdo2_d = ld_src[7];
        tx2_d = {ld_src[6:0], 1'b0};
      end else if (conv_mode) begin
        sdo_d = ld_src[15];
        tx_d = {ld_src[14:0], 1'b0};
      end else begin
        sdo_d = 1'b0;
        tx_d = 16'h0000;
      end
    end else begin
      if (sck_rise && (phase_q != PH_IDLE)) begin // [R5] [R13]
        rx_d = rx_next;
        bit_cnt_d = 5'(bit_cnt_q + 5'h01);
        case (phase_q)
          PH_ADDR: begin
            if (bit_cnt_q == `ASHI_ADDR_LAST_BIT) begin // [R6]
              rd_d = rx_next[7];
              addr_d = rx_next[6:0];
              phase_d = PH_DATA;
              if (rx_next[7])
                tx_d = {reg_read(rx_next[6:0], reg_q[rx_next[3:0]], status), 8'h00}; // [R2]
            end
          end
          PH_DATA: begin
            if (bit_cnt_q == `ASHI_DATA_LAST_BIT) begin
              phase_d = PH_SKIP;
              // status is read-only, unmapped writes vanish
              if (!rd_q && reg_mapped(addr_q) && (addr_q[3:0] != `ASHI_REG_STATUS))
                reg_d[addr_q[3:0]] = rx_next[7:0]; // [R6]
            end
          end
          PH_CMD: begin
            if (bit_cnt_q == `ASHI_CMD_LAST_BIT) begin // [R7]
              phase_d = PH_SKIP;
              if (rx_next[`ASHI_CMD_CHSEL_BIT])
                chan_d = rx_next[3:0];
              else if (rx_next[4:0] == `ASHI_CMD_EXIT)
                reg_d[`ASHI_REG_MODE][`ASHI_MODE_CONV_BIT] = 1'b0;
            end
          end
          PH_SKIP: begin
          end
          default: phase_d = PH_IDLE;
        endcase
      end
      if (sck_fall) begin // [R4] [R5]
        sdo_d = tx_q[15];
        tx_d = {tx_q[14:0], 1'b0};
        sdo2_d = tx2_q[7];
        tx2_d = {tx2_q[6:0], 1'b0};
      end
    end
    case (mfp_sel) // [R12]
      MFP_GPIO: begin
        mfp_out_d = reg_q[`ASHI_REG_GPIO][`ASHI_GPIO_OUT_BIT];
        mfp_oe_d = reg_q[`ASHI_REG_GPIO][`ASHI_GPIO_OE_BIT];
      end
      MFP_ALERT: begin
        mfp_out_d = alert_flag;
        mfp_oe_d = 1'b1;
      end
      MFP_BUSY: begin
        mfp_out_d = (conv_st_q == CV_BUSY);
        mfp_oe_d = 1'b1;
      end
      MFP_SDO2: begin
        // second lane only carries data in conversion mode
        mfp_out_d = sdo2_q;
        mfp_oe_d = 1'b1;
      end
      default: begin
        mfp_out_d = 1'b0;
        mfp_oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin // [R1]
      for (int i = 0; i < `ASHI_REG_COUNT; i++)
        reg_q[i] <= `ASHI_RST_OTHER;
      reg_q[`ASHI_REG_MODE] <= `ASHI_RST_MODE;
      reg_q[`ASHI_REG_MFP] <= `ASHI_RST_MFP;
      reg_q[`ASHI_REG_GPIO] <= `ASHI_RST_GPIO;
      phase_q <= PH_IDLE;
      conv_st_q <= CV_IDLE;
      bit_cnt_q <= 5'h00;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      tx2_q <= 8'h00;
      addr_q <= 7'h00;
      rd_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo2_q <= 1'b0;
      result_q <= 16'h0000;
      chan_q <= 4'h0;
      conv_start_q <= 1'b0;
      mfp_out_q <= 1'b0;
      mfp_oe_q <= 1'b0;
      sck_p_q <= 1'b0;
      cs_p_q <= 1'b1;
      cnv_p_q <= 1'b0;
    end else begin
      reg_q <= reg_d;
      phase_q <= phase_d;
      conv_st_q <= conv_st_d;
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      tx2_q <= tx2_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      sdo_q <= sdo_d;
      sdo2_q <= sdo2_d;
      result_q <= result_d;
      chan_q <= chan_d;
      conv_start_q <= conv_start_d;
      mfp_out_q <= mfp_out_d;
      mfp_oe_q <= mfp_oe_d;
      sck_p_q <= sck_s;
      cs_p_q <= cs_s;
      cnv_p_q <= cnv_s;
    end
  end

  assign sdo = sdo_q;
  assign multi_function_pin_out = mfp_out_q;
  assign multi_function_pin_oe = mfp_oe_q;
  assign conv_start = conv_start_q;
  assign channel_sel = chan_q;
  assign conversion_mode = conv_mode;

  sequence s_cnv_req;
    conv_mode && cnv_rise && (conv_st_q == CV_IDLE);
  endsequence

  sequence s_write_done;
    !cs_s && !cs_fall && sck_rise && (phase_q == PH_DATA) &&
    (bit_cnt_q == `ASHI_DATA_LAST_BIT) && !rd_q && (addr_q == 7'(`ASHI_REG_GPIO));
  endsequence

  sequence s_addr_read;
    !cs_s && !cs_fall && sck_rise && (phase_q == PH_ADDR) &&
    (bit_cnt_q == `ASHI_ADDR_LAST_BIT) && sdi_s && rx_q[6];
  endsequence

  AST_RESET_DEFAULTS: assert property (@(posedge clock) // [R1]
    $past(!reset_n) |-> (reg_q[`ASHI_REG_MODE] == `ASHI_RST_MODE) &&
    (reg_q[`ASHI_REG_MFP] == `ASHI_RST_MFP) && (phase_q == PH_IDLE))
    else $error("registers not at defaults after reset");

  AST_READ_ARMED: assert property (@(posedge clock) disable iff (!reset_n) // [R2]
    s_addr_read |=> rd_q && (phase_q == PH_DATA))
    else $error("read transaction not armed after address byte");

  AST_CONV_PRESENT: assert property (@(posedge clock) disable iff (!reset_n) // [R3]
    (conv_mode && cs_fall) |=> (sdo_q == $past(result_q[15])))
    else $error("result msb not presented at frame start");

  AST_SDO_FALL_ONLY: assert property (@(posedge clock) disable iff (!reset_n) // [R4]
    (!sck_fall && !cs_fall && !ld_done) |=> $stable(sdo_q))
    else $error("sdo changed without a falling serial clock");

  AST_SHIFT_FALL: assert property (@(posedge clock) disable iff (!reset_n) // [R5]
    (sck_fall && !cs_s && !cs_fall) |=> (sdo_q == $past(tx_q[15])))
    else $error("sdo did not shift on falling edge");

  AST_WRITE_LANDS: assert property (@(posedge clock) disable iff (!reset_n) // [R6]
    s_write_done |=> (reg_q[`ASHI_REG_GPIO] == $past(rx_next[7:0])))
    else $error("register write did not land");

  AST_CMD_EXIT: assert property (@(posedge clock) disable iff (!reset_n) // [R7]
    (!cs_s && !cs_fall && sck_rise && (phase_q == PH_CMD) &&
     (bit_cnt_q == `ASHI_CMD_LAST_BIT) && (rx_next[4:0] == `ASHI_CMD_EXIT))
    |=> !conv_mode)
    else $error("exit command ignored");

  AST_CNV_START: assert property (@(posedge clock) disable iff (!reset_n) // [R8]
    s_cnv_req |=> conv_start ##1 (!conv_start && (conv_st_q == CV_BUSY || $past(conv_done))))
    else $error("convert start pulse wrong");

  AST_FRAME_CLOSED: assert property (@(posedge clock) disable iff (!reset_n) // [R9]
    cs_s |=> (phase_q == PH_IDLE) && (bit_cnt_q == 5'h00))
    else $error("frame not closed by chip select");

  AST_MFP_BUSY: assert property (@(posedge clock) disable iff (!reset_n) // [R12]
    (mfp_sel == MFP_BUSY) |=> multi_function_pin_oe &&
    (multi_function_pin_out == $past(conv_st_q == CV_BUSY)))
    else $error("busy indicator wrong");

  AST_RX_RISE: assert property (@(posedge clock) disable iff (!reset_n) // [R13]
    (sck_rise && !cs_s && !cs_fall && (phase_q != PH_IDLE)) |=> (rx_q[0] == $past(sdi_s)))
    else $error("sdi not sampled on rising edge");
endmodule // ashi_top

// ---- hdl/ashi_defs.svh ----
// constants of the converter serial host interface
// assumes inclusion by bare name from the main module
`ifndef ASHI_DEFS_SVH
`define ASHI_DEFS_SVH

`define ASHI_REG_COUNT 16
`define ASHI_REG_MODE 4'h0
`define ASHI_REG_MFP 4'h1
`define ASHI_REG_GPIO 4'h2
`define ASHI_REG_STATUS 4'h3

`define ASHI_MODE_CONV_BIT 0
`define ASHI_MFP_SEL_MSB 1
`define ASHI_MFP_SEL_LSB 0
`define ASHI_GPIO_OUT_BIT 0
`define ASHI_GPIO_OE_BIT 1
`define ASHI_STAT_GPIN_BIT 0
`define ASHI_STAT_BUSY_BIT 1
`define ASHI_STAT_ALERT_BIT 2

`define ASHI_RST_MODE 8'h00
`define ASHI_RST_MFP 8'h00
`define ASHI_RST_GPIO 8'h00
`define ASHI_RST_OTHER 8'h00

`define ASHI_ADDR_LAST_BIT 5'h07
`define ASHI_DATA_LAST_BIT 5'h0F
`define ASHI_CMD_LAST_BIT 5'h04
`define ASHI_CMD_EXIT 5'h0A
`define ASHI_CMD_CHSEL_BIT 4

`endif

// ---- hdl/ashi_pkg.sv ----
// types of the converter serial host interface
// assumes no other file; only the main module includes the constants header
package ashi_pkg;
  typedef logic [15:0] ashi_result_t;
  typedef logic [3:0] ashi_chan_t;
  typedef enum logic [1:0] {MFP_GPIO, MFP_ALERT, MFP_BUSY, MFP_SDO2} ashi_mfp_t;
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_CMD, PH_SKIP} ashi_phase_t;
  typedef enum logic {CV_IDLE, CV_BUSY} ashi_conv_t;
endpackage

// ---- hdl/ashi_sync.sv ----
// two-flop synchroniser for a group of pin inputs
// assumes every bit is an independent level from outside the clock domain
`timescale 1ns/1ns
module ashi_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] pins_sync
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= pins;
      stage2_q <= stage1_q;
    end
  end

  assign pins_sync = stage2_q;
endmodule // ashi_sync

// ---- verification/ashi_host_model.sv ----
// host controller model: serial bus master driving sck, cs_n, sdi, convert_start
// assumes the bench calls its tasks one at a time, off the rising clock edge
`timescale 1ns/1ns
module ashi_host_model (
  input wire logic clock,
  output logic sck,
  output logic cs_n,
  output logic sdi,
  output logic convert_start,
  input wire logic sdo,
  input wire logic sdo2
);
  bit tied;
  logic [15:0] lane2;

  initial begin
    tied = 1'b0;
    lane2 = 16'h0000;
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    convert_start = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clock);
  endtask

  // a 4-wire host drives convert_start from its chip select line
  task automatic tie(input bit on);
    tied = on;
    if (!on)
      convert_start = 1'b0;
  endtask

  task automatic select();
    gap(1);
    cs_n = 1'b0;
    if (tied)
      convert_start = 1'b0;
    gap(8);
  endtask

  // 8 clocks per sck phase keeps well above the oversampling need
  task automatic shift(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    lane2 = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      gap(8);
      rx[i] = sdo;
      lane2[i] = sdo2;
      sck = 1'b1;
      gap(8);
      sck = 1'b0;
    end
  endtask

  task automatic deselect();
    gap(8);
    cs_n = 1'b1;
    if (tied)
      convert_start = 1'b1;
    // released line shows a changed level, not the last bit
    sdi = ~sdi;
    gap(8);
  endtask

  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
    select();
    shift(tx, n, rx);
    deselect();
  endtask

  task automatic pulse_cnv();
    convert_start = 1'b1;
    gap(16);
    convert_start = 1'b0;
    gap(8);
  endtask
endmodule // ashi_host_model

// ---- verification/adc_serial_host_interface_tb_top.sv ----
// self-checking bench of the converter serial host interface
// assumes ashi_pkg and ashi_top compiled first; core side modelled inline
`timescale 1ns/1ns
module adc_serial_host_interface_tb_top;
  import ashi_pkg::*;
  logic clock, reset_n, sck, cs_n, sdi, convert_start, ext_pin, sdo;
  logic pin_out, pin_oe, conv_start, conv_done, alert_flag, conversion_mode, mfp_wire;
  ashi_result_t conv_data;
  ashi_chan_t channel_sel;
  logic [15:0] rx;
  int errors, total_checks, starts, s0;

  // pin level resolves from both drivers
  assign mfp_wire = pin_oe ? pin_out : ext_pin;
  always #4 clock = ~clock;
  always @(posedge clock) if (conv_start === 1'b1) starts++;

  ashi_top u_dut (.clock(clock), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .sdi(sdi),
    .convert_start(convert_start), .multi_function_pin_in(mfp_wire), .sdo(sdo),
    .multi_function_pin_out(pin_out), .multi_function_pin_oe(pin_oe),
    .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
    .alert_flag(alert_flag), .channel_sel(channel_sel), .conversion_mode(conversion_mode));
  ashi_host_model u_host (.clock(clock), .sck(sck), .cs_n(cs_n), .sdi(sdi),
    .convert_start(convert_start), .sdo(sdo), .sdo2(mfp_wire));

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.frame({1'b0, a, d}, 16, rx);
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    u_host.frame({1'b1, a, 8'h00}, 16, rx);
    check(what, {8'h00, rx[7:0]}, {8'h00, exp});
  endtask

  // core side: one-cycle done pulse with the result, then the bus moves on
  task automatic core_done(input logic [15:0] d);
    conv_data = d;
    conv_done = 1'b1;
    u_host.gap(1);
    conv_done = 1'b0;
    conv_data = ~d;
    u_host.gap(6);
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask

  task automatic t_defaults();
    for (int a = 0; a < 6; a++) rd_chk("reg default", 7'(a), 8'h00);
    check("mode", 16'(conversion_mode), 16'h0000);
    check("oe", 16'(pin_oe), 16'h0000);
  endtask

  task automatic t_regs();
    wr(7'h05, 8'hA5);
    rd_chk("scratch", 7'h05, 8'hA5);
    wr(7'h40, 8'h3C);
    rd_chk("unmapped", 7'h40, 8'h00);
    ext_pin = 1'b1;
    wr(7'h03, 8'hFF);
    rd_chk("status ro", 7'h03, 8'h01);
  endtask

  task automatic t_mfp();
    wr(7'h02, 8'h03);
    check("gpio out", 16'(pin_out), 16'h0001);
    check("gpio oe", 16'(pin_oe), 16'h0001);
    wr(7'h01, 8'h01);
    alert_flag = 1'b1;
    u_host.gap(6);
    check("alert hi", 16'(pin_out), 16'h0001);
    rd_chk("status alert", 7'h03, 8'h05);
    alert_flag = 1'b0;
    u_host.gap(6);
    check("alert lo", 16'(pin_out), 16'h0000);
  endtask

  task automatic t_conv();
    wr(7'h01, 8'h02);
    wr(7'h00, 8'h01);
    check("conv mode", 16'(conversion_mode), 16'h0001);
    u_host.frame(16'h0015, 5, rx);
    check("channel", 16'(channel_sel), 16'h0005);
    s0 = starts;
    u_host.pulse_cnv();
    check("one start", 16'(starts - s0), 16'h0001);
    check("busy pin", 16'(pin_out), 16'h0001);
    core_done(16'hBEEF);
    check("busy end", 16'(pin_out), 16'h0000);
    u_host.frame(16'h0000, 16, rx);
    check("result", rx, 16'hBEEF);
    u_host.frame(16'h000A, 5, rx);
    check("exit", 16'(conversion_mode), 16'h0000);
    s0 = starts;
    u_host.pulse_cnv();
    check("start refused", 16'(starts - s0), 16'h0000);
  endtask

  // chip select end doubles as convert start
  task automatic t_tied();
    wr(7'h01, 8'h02);
    wr(7'h00, 8'h01);
    u_host.tie(1'b1);
    s0 = starts;
    u_host.frame(16'h0000, 16, rx);
    check("tied start", 16'(starts - s0), 16'h0001);
    core_done(16'hC3A5);
    u_host.frame(16'h0000, 16, rx);
    check("tied result", rx, 16'hC3A5);
    check("tied restart", 16'(starts - s0), 16'h0002);
    core_done(16'h0000);
    u_host.frame(16'h000A, 5, rx);
    u_host.tie(1'b0);
    check("tied exit", 16'(conversion_mode), 16'h0000);
    check("tied refused", 16'(starts - s0), 16'h0002);
  endtask

  // select held low across the conversion, result split over two lanes
  task automatic t_held();
    wr(7'h01, 8'h03);
    wr(7'h00, 8'h01);
    u_host.select();
    u_host.pulse_cnv();
    core_done(16'h96C3);
    u_host.shift(16'h0000, 8, rx);
    check("held lane1", {8'h00, rx[7:0]}, 16'h0096);
    check("held lane2", {8'h00, u_host.lane2[7:0]}, 16'h00C3);
    u_host.deselect();
    u_host.frame(16'h000A, 5, rx);
    check("held exit", 16'(conversion_mode), 16'h0000);
  endtask

  task automatic t_reset();
    wr(7'h05, 8'h5A);
    wr(7'h00, 8'h01);
    do_reset();
    check("mode rst", 16'(conversion_mode), 16'h0000);
    check("chan rst", 16'(channel_sel), 16'h0000);
    rd_chk("scratch rst", 7'h05, 8'h00);
    rd_chk("mfp rst", 7'h01, 8'h00);
  endtask

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    ext_pin = 1'b0;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    alert_flag = 1'b0;
    errors = 0;
    total_checks = 0;
    starts = 0;
    do_reset();
    t_defaults();
    t_regs();
    t_mfp();
    t_conv();
    t_tied();
    t_held();
    t_reset();
    close_out();
  end

  // run needs about 8.6k cycles; the 50k-cycle limit allows over five and a half times that
  initial begin
    #400000;
    errors++;
    close_out();
  end
endmodule // adc_serial_host_interface_tb_top
